// ---- hw/hbd_core.sv ----
// 8-bit core slice: halt, break entry and exit, and first opcode group
// Behaviour
// - halt clears the interrupt mask bit
// - mask stays clear after interrupt wake-up
// - reset leaves the interrupt mask set
// - halt stops the core clock
// - clock restarts only after stabilization delay
// - break loads interrupt opcode into instruction register
// - break vector FFFC, or FEFC in monitor
// - break waits for current instruction to finish
// - match on last cycle starts break next
// - return ends break once request dropped
// - add with carry, five flags updated
// - add without carry, five flags updated
// - memory operand cycle counts per addressing mode
// - stack pointer adjust, signed immediate, two cycles
// - index pair adjust, signed immediate, two cycles
// - shift left, bit 7 to carry
// - shift right keeps bit 7, bit 0 carry
// - branch when carry clear, three cycles
// - branch when carry set, three cycles
// - branch when zero set, three cycles
// - clear one direct page bit, four cycles
// - mask set blocks maskable interrupt requests
`timescale 1ns/1ns
module hbd_core #(
	parameter int STAB_CYCLES = hbd_pkg::STAB_CYCLES
) (
	input  wire logic        i_clk,
	input  wire logic        i_srst,
	input  wire logic [7:0]  i_rdata,
	input  wire logic        i_irq,
	input  wire logic        i_brk,
	input  wire logic        i_monitor,
	output logic      [15:0] o_addr,
	output logic             o_rd,
	output logic             o_we,
	output logic      [7:0]  o_wdata,
	output logic             o_core_clk_en,
	output logic             o_break_active,
	output logic             o_halted,
	output logic      [7:0]  o_flags,
	output logic             o_boundary
);
	typedef enum logic [2:0] {S_VEC, S_FETCH, S_EXE, S_PUSH, S_PULL, S_HALT} hbd_state_t;

	hbd_state_t          state;
	hbd_state_t          next_state;
	hbd_pkg::hbd_vsel_t  vsel;
	hbd_pkg::hbd_vsel_t  next_vsel;
	hbd_pkg::hbd_dec_t   dcur;
	logic [2:0]          c;
	logic [2:0]          next_c;
	logic [15:0]         pc;
	logic [15:0]         next_pc;
	logic [15:0]         stk;
	logic [15:0]         next_stk;
	logic [15:0]         t;
	logic [15:0]         next_t;
	logic [15:0]         ea;
	logic [15:0]         hx;
	logic [15:0]         vbase;
	logic [7:0]          ir;
	logic [7:0]          next_ir;
	logic [7:0]          tmp;
	logic [7:0]          next_tmp;
	logic [7:0]          a;
	logic [7:0]          next_a;
	logic [7:0]          x;
	logic [7:0]          next_x;
	logic [7:0]          h;
	logic [7:0]          next_h;
	logic [7:0]          flags;
	logic [7:0]          next_flags;
	logic                pre;
	logic                next_pre;
	logic                brk_active;
	logic                next_brk;
	logic                boundary;
	logic                halt_enter;
	logic                resume;
	logic [2:0]          first_byte;
	logic [2:0]          last_byte;
	logic                take;

	hbd_alu_if alu_bus ();

	hbd_alu u_alu (
		.bus (alu_bus.alu)
	);

	hbd_halt_gate #(
		.STAB_CYCLES (STAB_CYCLES)
	) u_gate (
		.i_clk    (i_clk),
		.i_srst   (i_srst),
		.i_enter  (halt_enter),
		.i_wake   (i_irq),
		.o_clk_en (o_core_clk_en),
		.o_resume (resume)
	);

	// in fetch the opcode is still on the data bus, later it sits in ir
	assign dcur = hbd_pkg::hbd_decode(pre, (state == S_FETCH) ? i_rdata : ir);
	assign hx = {h, x};
	assign first_byte = pre ? 3'h2 : 3'h1;
	assign last_byte = first_byte + hbd_pkg::hbd_operand_bytes(dcur.mode);

	always_comb begin
		case (dcur.mode)
			hbd_pkg::M_DIR: ea = {8'h00, t[7:0]};
			hbd_pkg::M_EXT: ea = t;
			hbd_pkg::M_IX2: ea = hx + t;
			hbd_pkg::M_IX1: ea = hx + {8'h00, t[7:0]};
			hbd_pkg::M_IX:  ea = hx;
			hbd_pkg::M_STK1: ea = stk + {8'h00, t[7:0]};
			hbd_pkg::M_STK2: ea = stk + t;
			default:        ea = pc;
		endcase
	end

	always_comb begin
		case (vsel)
			hbd_pkg::V_RESET: vbase = hbd_pkg::VEC_RESET;
			hbd_pkg::V_IRQ:   vbase = hbd_pkg::VEC_IRQ;
			hbd_pkg::V_BRK:   vbase = i_monitor ? hbd_pkg::VEC_BREAK_MON : hbd_pkg::VEC_BREAK;
			default:          vbase = hbd_pkg::VEC_BREAK;
		endcase
	end

	always_comb begin
		case (dcur.cls)
			hbd_pkg::C_BR_CC: take = !flags[hbd_pkg::FLG_C];
			hbd_pkg::C_BR_CS: take = flags[hbd_pkg::FLG_C];
			hbd_pkg::C_BR_EQ: take = flags[hbd_pkg::FLG_Z];
			default:        take = 1'b0;
		endcase
	end

	always_comb begin
		next_state = state;
		next_vsel = vsel;
		next_c = c;
		next_pc = pc;
		next_stk = stk;
		next_t = t;
		next_ir = ir;
		next_tmp = tmp;
		next_a = a;
		next_x = x;
		next_h = h;
		next_flags = flags;
		next_pre = pre;
		next_brk = brk_active;
		boundary = 1'b0;
		halt_enter = 1'b0;
		o_addr = pc;
		o_rd = 1'b0;
		o_we = 1'b0;
		o_wdata = 8'h00;
		alu_bus.op = dcur.cls;
		alu_bus.a = a;
		alu_bus.m = i_rdata;
		alu_bus.flg_in = flags;
		case (state)
			S_VEC: begin
				o_rd = 1'b1;
				o_addr = vbase + {15'h0000, c[0]};
				if (!c[0]) begin
					next_pc = {i_rdata, pc[7:0]};
					// mask goes up after stacking, in the cycle that reads the high vector byte
					next_flags[hbd_pkg::FLG_I] = 1'b1;
					next_c = 3'h1;
				end else begin
					next_pc = {pc[15:8], i_rdata};
					next_c = 3'h0;
					next_state = S_FETCH;
				end
			end
			S_FETCH: begin
				o_rd = 1'b1;
				next_pc = pc + 16'h0001;
				if (!pre && i_rdata == hbd_pkg::OP_PREFIX_STK) begin
					next_pre = 1'b1;
					next_c = 3'h1;
				end else begin
					next_ir = i_rdata;
					case (dcur.cls)
						hbd_pkg::C_SHL, hbd_pkg::C_SHR: begin
							if (dcur.mode == hbd_pkg::M_INH) begin
								alu_bus.m = i_rdata[4] ? x : a;
								if (i_rdata[4])
									next_x = alu_bus.res;
								else
									next_a = alu_bus.res;
								next_flags = alu_bus.flg_out;
								boundary = 1'b1;
							end else begin
								next_c = c + 3'h1;
								next_state = S_EXE;
							end
						end
						hbd_pkg::C_HALT: begin
							next_flags[hbd_pkg::FLG_I] = 1'b0;
							halt_enter = 1'b1;
							next_state = S_HALT;
						end
						hbd_pkg::C_SOFT_INT: begin
							next_vsel = hbd_pkg::V_SWI;
							next_c = 3'h0;
							next_state = S_PUSH;
						end
						hbd_pkg::C_INT_RET: begin
							next_c = 3'h0;
							next_state = S_PULL;
						end
						hbd_pkg::C_NOP: begin
							boundary = 1'b1;
						end
						default: begin
							next_c = c + 3'h1;
							next_state = S_EXE;
						end
					endcase
				end
			end
			S_EXE: begin
				next_c = c + 3'h1;
				if (c < last_byte) begin
					o_rd = 1'b1;
					next_t = {t[7:0], i_rdata};
					next_pc = pc + 16'h0001;
				end else if (c == dcur.ncyc - 3'h1) begin
					boundary = 1'b1;
					case (dcur.cls)
						hbd_pkg::C_ADC, hbd_pkg::C_ADD, hbd_pkg::C_AND: begin
							o_rd = 1'b1;
							o_addr = ea;
							if (dcur.mode == hbd_pkg::M_IMM)
								next_pc = pc + 16'h0001;
							next_a = alu_bus.res;
							next_flags = alu_bus.flg_out;
						end
						hbd_pkg::C_SHL, hbd_pkg::C_SHR: begin
							alu_bus.m = tmp;
							o_addr = ea;
							o_we = 1'b1;
							o_wdata = alu_bus.res;
							next_flags = alu_bus.flg_out;
						end
						hbd_pkg::C_BIT_CLR: begin
							o_addr = ea;
							o_we = 1'b1;
							o_wdata = tmp & ~(8'h01 << ir[3:1]);
						end
						hbd_pkg::C_STK_ADJ: begin
							o_rd = 1'b1;
							next_pc = pc + 16'h0001;
							next_stk = stk + {{8{i_rdata[7]}}, i_rdata};
						end
						hbd_pkg::C_HX_ADJ: begin
							o_rd = 1'b1;
							next_pc = pc + 16'h0001;
							{next_h, next_x} = hx + {{8{i_rdata[7]}}, i_rdata};
						end
						default: begin
							if (take)
								next_pc = pc + {{8{t[7]}}, t[7:0]};
						end
					endcase
				end else if (c == dcur.ncyc - 3'h2) begin
					// read half of read-modify-write, kept for the final write cycle
					o_rd = 1'b1;
					o_addr = ea;
					next_tmp = i_rdata;
				end
			end
			S_PUSH: begin
				o_we = 1'b1;
				o_addr = stk;
				next_stk = stk - 16'h0001;
				case (c)
					3'h0:    o_wdata = pc[7:0];
					3'h1:    o_wdata = pc[15:8];
					3'h2:    o_wdata = x;
					3'h3:    o_wdata = a;
					default: o_wdata = flags;
				endcase
				next_c = c + 3'h1;
				if (c == hbd_pkg::PUSH_LAST) begin
					next_c = 3'h0;
					next_state = S_VEC;
				end
			end
			S_PULL: begin
				o_rd = 1'b1;
				o_addr = stk + 16'h0001;
				next_stk = stk + 16'h0001;
				next_c = c + 3'h1;
				case (c)
					3'h0:    next_flags = i_rdata | hbd_pkg::FLG_FIXED;
					3'h1:    next_a = i_rdata;
					3'h2:    next_x = i_rdata;
					3'h3:    next_pc = {i_rdata, pc[7:0]};
					default: next_pc = {pc[15:8], i_rdata};
				endcase
				if (c == hbd_pkg::PUSH_LAST) begin
					boundary = 1'b1;
					if (!i_brk)
						next_brk = 1'b0;
				end
			end
			default: begin
				// mask is left clear so the waking interrupt is taken
				if (resume)
					boundary = 1'b1;
			end
		endcase
		// break and interrupts are only looked at between instructions
		if (boundary) begin
			next_c = 3'h0;
			next_pre = 1'b0;
			if (i_brk && !brk_active) begin
				next_ir = hbd_pkg::OP_SOFT_INT;
				next_vsel = hbd_pkg::V_BRK;
				next_brk = 1'b1;
				next_state = S_PUSH;
			end else if (i_irq && !flags[hbd_pkg::FLG_I]) begin
				next_vsel = hbd_pkg::V_IRQ;
				next_state = S_PUSH;
			end else begin
				next_state = S_FETCH;
			end
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			state <= S_VEC;
			vsel <= hbd_pkg::V_RESET;
			c <= 3'h0;
			pre <= 1'b0;
			ir <= 8'h00;
			t <= 16'h0000;
			tmp <= 8'h00;
		end else begin
			state <= next_state;
			vsel <= next_vsel;
			c <= next_c;
			pre <= next_pre;
			ir <= next_ir;
			t <= next_t;
			tmp <= next_tmp;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			pc <= 16'h0000;
			stk <= hbd_pkg::STK_RESET;
			a <= 8'h00;
			x <= 8'h00;
			h <= 8'h00;
			flags <= hbd_pkg::FLG_RESET;
		end else begin
			pc <= next_pc;
			stk <= next_stk;
			a <= next_a;
			x <= next_x;
			h <= next_h;
			flags <= next_flags;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_srst)
			brk_active <= 1'b0;
		else
			brk_active <= next_brk;
	end

	assign o_break_active = brk_active;
	assign o_halted = (state == S_HALT);
	assign o_flags = flags;
	assign o_boundary = boundary;
endmodule // hbd_core

// ---- hw/hbd_pkg.sv ----
// shared constants, types and opcode decoding for the halt, break and decode core
package hbd_pkg;
	localparam logic [7:0]  OP_PREFIX_STK = 8'h9E;
	localparam logic [7:0]  OP_STK_ADJ    = 8'hA7;
	localparam logic [7:0]  OP_HX_ADJ     = 8'hAF;
	localparam logic [7:0]  OP_BR_CC      = 8'h24;
	localparam logic [7:0]  OP_BR_CS      = 8'h25;
	localparam logic [7:0]  OP_BR_EQ      = 8'h27;
	localparam logic [7:0]  OP_SOFT_INT   = 8'h83;
	localparam logic [7:0]  OP_INT_RET    = 8'h80;
	localparam logic [7:0]  OP_HALT       = 8'h8E;
	localparam logic [3:0]  LO_ADC        = 4'h9;
	localparam logic [3:0]  LO_ADD        = 4'hB;
	localparam logic [3:0]  LO_AND        = 4'h4;
	localparam logic [3:0]  LO_SHL        = 4'h8;
	localparam logic [3:0]  LO_SHR        = 4'h7;
	localparam logic [3:0]  HI_BIT_CLR    = 4'h1;
	localparam int          FLG_V         = 7;
	localparam int          FLG_H         = 4;
	localparam int          FLG_I         = 3;
	localparam int          FLG_N         = 2;
	localparam int          FLG_Z         = 1;
	localparam int          FLG_C         = 0;
	localparam logic [7:0]  FLG_FIXED     = 8'h60;
	localparam logic [7:0]  FLG_RESET     = 8'h68;
	localparam logic [15:0] STK_RESET     = 16'h00FF;
	localparam logic [15:0] VEC_RESET     = 16'hFFFE;
	localparam logic [15:0] VEC_BREAK     = 16'hFFFC;
	localparam logic [15:0] VEC_BREAK_MON = 16'hFEFC;
	localparam logic [15:0] VEC_IRQ       = 16'hFFFA;
	localparam int          STAB_CYCLES   = 4096;
	localparam logic [2:0]  CYC_INH       = 3'h1;
	localparam logic [2:0]  CYC_IMM       = 3'h2;
	localparam logic [2:0]  CYC_DIR       = 3'h3;
	localparam logic [2:0]  CYC_EXT       = 3'h4;
	localparam logic [2:0]  CYC_IX2       = 3'h4;
	localparam logic [2:0]  CYC_IX1       = 3'h3;
	localparam logic [2:0]  CYC_IX        = 3'h2;
	localparam logic [2:0]  CYC_STK1      = 3'h4;
	localparam logic [2:0]  CYC_STK2      = 3'h5;
	localparam logic [2:0]  CYC_ADJ       = 3'h2;
	localparam logic [2:0]  CYC_REL       = 3'h3;
	localparam logic [2:0]  CYC_BIT_CLR   = 3'h4;
	localparam logic [2:0]  PUSH_LAST     = 3'h4;

	typedef enum logic [3:0] {
		C_NOP, C_ADC, C_ADD, C_AND, C_SHL, C_SHR, C_STK_ADJ, C_HX_ADJ,
		C_BR_CC, C_BR_CS, C_BR_EQ, C_BIT_CLR, C_SOFT_INT, C_INT_RET, C_HALT
	} hbd_cls_t;
	typedef enum logic [3:0] {M_INH, M_IMM, M_DIR, M_EXT, M_IX2, M_IX1, M_IX, M_STK1, M_STK2, M_REL} hbd_mode_t;
	typedef enum logic [1:0] {V_RESET, V_SWI, V_BRK, V_IRQ} hbd_vsel_t;
	typedef struct packed {
		hbd_cls_t  cls;
		hbd_mode_t mode;
		logic [2:0] ncyc;
	} hbd_dec_t;

	function automatic logic [2:0] hbd_alu_cycles(input hbd_mode_t m);
		case (m)
			M_IMM:   return CYC_IMM;
			M_DIR:   return CYC_DIR;
			M_EXT:   return CYC_EXT;
			M_IX2:   return CYC_IX2;
			M_IX1:   return CYC_IX1;
			M_IX:    return CYC_IX;
			M_STK1:  return CYC_STK1;
			M_STK2:  return CYC_STK2;
			default: return CYC_INH;
		endcase
	endfunction

	function automatic logic [2:0] hbd_operand_bytes(input hbd_mode_t m);
		case (m)
			M_DIR, M_IX1, M_STK1, M_REL: return 3'h1;
			M_EXT, M_IX2, M_STK2:        return 3'h2;
			default:                    return 3'h0;
		endcase
	endfunction

	function automatic hbd_dec_t hbd_decode(input logic pre, input logic [7:0] op);
		hbd_dec_t d;
		logic [3:0] hi;
		logic [3:0] lo;
		logic alu_lo;
		logic shf_lo;
		hi = op[7:4];
		lo = op[3:0];
		alu_lo = (lo == LO_ADC) || (lo == LO_ADD) || (lo == LO_AND);
		shf_lo = (lo == LO_SHL) || (lo == LO_SHR);
		d.cls = C_NOP;
		d.mode = M_INH;
		d.ncyc = CYC_INH;
		if (alu_lo)
			d.cls = (lo == LO_ADC) ? C_ADC : ((lo == LO_ADD) ? C_ADD : C_AND);
		else if (shf_lo)
			d.cls = (lo == LO_SHL) ? C_SHL : C_SHR;
		if (!pre) begin
			if (op == OP_STK_ADJ || op == OP_HX_ADJ) begin
				d.cls = (op == OP_STK_ADJ) ? C_STK_ADJ : C_HX_ADJ;
				d.mode = M_IMM;
				d.ncyc = CYC_ADJ;
			end else if (hi >= 4'hA && alu_lo) begin
				case (hi)
					4'hA:    d.mode = M_IMM;
					4'hB:    d.mode = M_DIR;
					4'hC:    d.mode = M_EXT;
					4'hD:    d.mode = M_IX2;
					4'hE:    d.mode = M_IX1;
					default: d.mode = M_IX;
				endcase
				d.ncyc = hbd_alu_cycles(d.mode);
			end else if (hi >= 4'h3 && hi <= 4'h7 && shf_lo) begin
				case (hi)
					4'h3:       d.mode = M_DIR;
					4'h4, 4'h5: d.mode = M_INH;
					4'h6:       d.mode = M_IX1;
					default:    d.mode = M_IX;
				endcase
				d.ncyc = (d.mode == M_INH) ? CYC_INH : hbd_alu_cycles(d.mode) + 3'h1;
			end else if (op == OP_BR_CC || op == OP_BR_CS || op == OP_BR_EQ) begin
				d.cls = (op == OP_BR_CC) ? C_BR_CC : ((op == OP_BR_CS) ? C_BR_CS : C_BR_EQ);
				d.mode = M_REL;
				d.ncyc = CYC_REL;
			end else if (hi == HI_BIT_CLR && lo[0]) begin
				d.cls = C_BIT_CLR;
				d.mode = M_DIR;
				d.ncyc = CYC_BIT_CLR;
			end else if (op == OP_SOFT_INT) begin
				d.cls = C_SOFT_INT;
			end else if (op == OP_INT_RET) begin
				d.cls = C_INT_RET;
			end else if (op == OP_HALT) begin
				d.cls = C_HALT;
			end else begin
				d.cls = C_NOP;
			end
		end else begin
			if ((hi == 4'hE || hi == 4'hD) && alu_lo) begin
				d.mode = (hi == 4'hE) ? M_STK1 : M_STK2;
				d.ncyc = hbd_alu_cycles(d.mode);
			end else if (hi == 4'h6 && shf_lo) begin
				d.mode = M_STK1;
				d.ncyc = hbd_alu_cycles(M_STK1) + 3'h1;
			end else begin
				d.cls = C_NOP;
			end
		end
		return d;
	endfunction
endpackage

// ---- hw/hbd_alu_if.sv ----
// operand and flag bundle between the core sequencer and its arithmetic unit
`timescale 1ns/1ns
interface hbd_alu_if;
	hbd_pkg::hbd_cls_t op;
	logic [7:0]        a;
	logic [7:0]        m;
	logic [7:0]        flg_in;
	logic [7:0]        res;
	logic [7:0]        flg_out;
	modport core (output op, output a, output m, output flg_in, input res, input flg_out);
	modport alu  (input op, input a, input m, input flg_in, output res, output flg_out);
endinterface

// ---- hw/hbd_alu.sv ----
// add, and, shift arithmetic with condition flag generation
`timescale 1ns/1ns
module hbd_alu (
	hbd_alu_if.alu bus
);
	logic [8:0] sum;
	logic [4:0] half;
	logic       cin;

	assign cin  = (bus.op == hbd_pkg::C_ADC) ? bus.flg_in[hbd_pkg::FLG_C] : 1'b0;
	assign sum  = {1'b0, bus.a} + {1'b0, bus.m} + {8'h00, cin};
	assign half = {1'b0, bus.a[3:0]} + {1'b0, bus.m[3:0]} + {4'h0, cin};

	always_comb begin
		bus.res = bus.a;
		bus.flg_out = bus.flg_in | hbd_pkg::FLG_FIXED;
		case (bus.op)
			hbd_pkg::C_ADC, hbd_pkg::C_ADD: begin
				bus.res = sum[7:0];
				bus.flg_out[hbd_pkg::FLG_H] = half[4];
				bus.flg_out[hbd_pkg::FLG_C] = sum[8];
				bus.flg_out[hbd_pkg::FLG_V] = (bus.a[7] & bus.m[7] & ~sum[7]) | (~bus.a[7] & ~bus.m[7] & sum[7]);
			end
			hbd_pkg::C_AND: begin
				bus.res = bus.a & bus.m;
				bus.flg_out[hbd_pkg::FLG_V] = 1'b0;
			end
			hbd_pkg::C_SHL: begin
				bus.res = {bus.m[6:0], 1'b0};
				bus.flg_out[hbd_pkg::FLG_C] = bus.m[7];
				bus.flg_out[hbd_pkg::FLG_V] = bus.m[6] ^ bus.m[7];
			end
			hbd_pkg::C_SHR: begin
				bus.res = {bus.m[7], bus.m[7:1]};
				bus.flg_out[hbd_pkg::FLG_C] = bus.m[0];
				bus.flg_out[hbd_pkg::FLG_V] = bus.m[7] ^ bus.m[0];
			end
			default: begin
				bus.res = bus.a;
			end
		endcase
		if (bus.op inside {hbd_pkg::C_ADC, hbd_pkg::C_ADD, hbd_pkg::C_AND, hbd_pkg::C_SHL, hbd_pkg::C_SHR}) begin
			bus.flg_out[hbd_pkg::FLG_N] = bus.res[7];
			bus.flg_out[hbd_pkg::FLG_Z] = (bus.res == 8'h00);
		end
	end
endmodule // hbd_alu

// ---- hw/hbd_halt_gate.sv ----
// core clock gate for halt, with oscillator stabilization wait on wake-up
`timescale 1ns/1ns
module hbd_halt_gate #(
	parameter int STAB_CYCLES = hbd_pkg::STAB_CYCLES
) (
	input  wire logic i_clk,
	input  wire logic i_srst,
	input  wire logic i_enter,
	input  wire logic i_wake,
	output logic      o_clk_en,
	output logic      o_resume
);
	typedef enum logic [1:0] {G_RUN, G_HALT, G_STAB} hbd_gate_t;
	localparam int CW = $clog2(STAB_CYCLES + 1);
	localparam logic [CW-1:0] CNT_LAST = CW'(STAB_CYCLES - 1);

	hbd_gate_t     state;
	logic [CW-1:0] cnt;

	if (STAB_CYCLES < 1) begin : g_bad_stab
		$error("STAB_CYCLES must be at least 1");
	end

	assign o_clk_en = (state == G_RUN);
	assign o_resume = (state == G_STAB) && (cnt == CNT_LAST);

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			state <= G_RUN;
			cnt <= '0;
		end else begin
			case (state)
				G_RUN: begin
					if (i_enter)
						state <= G_HALT;
				end
				G_HALT: begin
					cnt <= '0;
					if (i_wake)
						state <= G_STAB;
				end
				default: begin
					cnt <= cnt + CW'(1);
					if (cnt == CNT_LAST)
						state <= G_RUN;
				end
			endcase
		end
	end
endmodule // hbd_halt_gate

// ---- bench/hbd_core_properties.sv ----
// concurrent checks on the halt, break and decode core ports
`timescale 1ns/1ns
module hbd_core_properties #(
	parameter int STAB_CYCLES = 8
) (
	input wire logic        i_clk,
	input wire logic        i_srst,
	input wire logic        i_brk,
	input wire logic        i_monitor,
	input wire logic [15:0] o_addr,
	input wire logic        o_rd,
	input wire logic        o_we,
	input wire logic        o_core_clk_en,
	input wire logic        o_break_active,
	input wire logic        o_halted,
	input wire logic [7:0]  o_flags,
	input wire logic        o_boundary
);
	int unsigned low_cnt;

	default clocking @(posedge i_clk); endclocking
	default disable iff (i_srst);

	// length of the current clock-off stretch
	always_ff @(posedge i_clk) begin
		if (i_srst || o_core_clk_en)
			low_cnt <= 0;
		else
			low_cnt <= low_cnt + 1;
	end

	sequence s_push_five;
		o_we [*5];
	endsequence
	sequence s_vec_fetch;
		o_rd && o_addr == (i_monitor ? hbd_pkg::VEC_BREAK_MON : hbd_pkg::VEC_BREAK);
	endsequence

	a_reset_sets_mask: assert property ($fell(i_srst) |-> o_flags == hbd_pkg::FLG_RESET)
		else $error("flags wrong after reset");
	a_halt_clears_mask: assert property ($rose(o_halted) |-> !o_flags[hbd_pkg::FLG_I])
		else $error("mask still set in halt");
	a_halt_gates_clock: assert property ($rose(o_halted) |-> !o_core_clk_en)
		else $error("clock runs in halt");
	a_stab_delay_kept: assert property ($rose(o_core_clk_en) |-> low_cnt > STAB_CYCLES)
		else $error("clock restarted early");
	a_wake_mask_clear: assert property ($rose(o_core_clk_en) |-> !o_flags[hbd_pkg::FLG_I])
		else $error("mask set on wake");
	a_break_at_boundary: assert property ($rose(o_break_active) |-> $past(o_boundary) && $past(i_brk))
		else $error("break entered mid instruction");
	a_break_entry_steps: assert property (o_boundary && i_brk && !o_break_active && !o_halted
		|=> s_push_five ##1 s_vec_fetch)
		else $error("break entry sequence wrong");
	a_break_exit_ok: assert property ($fell(o_break_active) |-> $past(o_boundary) && !$past(i_brk))
		else $error("break ended while requested");
	a_irq_only_unmasked: assert property (o_rd && o_addr == hbd_pkg::VEC_IRQ
		|-> !$past(o_flags[hbd_pkg::FLG_I], 6))
		else $error("interrupt taken while masked");
endmodule // hbd_core_properties

bind hbd_core hbd_core_properties #(.STAB_CYCLES(STAB_CYCLES)) u_props (.i_clk(i_clk), .i_srst(i_srst),
	.i_brk(i_brk), .i_monitor(i_monitor), .o_addr(o_addr), .o_rd(o_rd), .o_we(o_we),
	.o_core_clk_en(o_core_clk_en), .o_break_active(o_break_active), .o_halted(o_halted),
	.o_flags(o_flags), .o_boundary(o_boundary));

// ---- bench/hbd_mem_model.sv ----
// zero-wait memory beside the core bus, reads combinational
`timescale 1ns/1ns
module hbd_mem_model (
	input  wire logic        i_clk,
	input  wire logic [15:0] i_addr,
	input  wire logic        i_rd,
	input  wire logic        i_we,
	input  wire logic [7:0]  i_wdata,
	output logic      [7:0]  o_rdata
);
	logic [7:0] ram [0:65535];
	logic [7:0] last = 8'h00;

	// idle bus shows the inverse so a late sample cannot match by luck
	assign o_rdata = i_rd ? ram[i_addr] : ~last;
	always @(posedge i_clk) begin
		if (i_rd)
			last <= ram[i_addr];
		if (i_we)
			ram[i_addr] <= i_wdata;
	end
endmodule // hbd_mem_model

// ---- bench/hbd_core_tb_top.sv ----
// self-checking bench for the halt, break and decode core
`timescale 1ns/1ns
module hbd_core_tb_top;
	localparam int STAB = 8;
	typedef struct {
		logic [31:0] code;
		int          len;
		logic [7:0]  flg;
		int          cyc;
	} hbd_row_t;
	logic        i_clk;
	logic        i_srst;
	logic        i_irq;
	logic        i_brk;
	logic        i_monitor;
	logic [7:0]  i_rdata;
	logic [15:0] o_addr;
	logic        o_rd;
	logic        o_we;
	logic [7:0]  o_wdata;
	logic        o_core_clk_en;
	logic        o_break_active;
	logic        o_halted;
	logic [7:0]  o_flags;
	logic        o_boundary;
	int          fails;
	int          comparisons;
	int          row_i;
	int          n;
	int          w;
	int unsigned pc;
	// taken branches skip two shift opcodes that would spoil flags and counts
	hbd_row_t rows [23] = '{
		'{32'hAB7F0000, 2, 8'h68, 2},
		'{32'hA9010000, 2, 8'hFC, 2},
		'{32'h48000000, 1, 8'hFB, 1},
		'{32'hAB810000, 2, 8'h6C, 2},
		'{32'h47000000, 1, 8'h6D, 1},
		'{32'h25024848, 4, 8'h6D, 3},
		'{32'h24020000, 2, 8'h6D, 3},
		'{32'h27020000, 2, 8'h6D, 3},
		'{32'hA4000000, 2, 8'h6B, 2},
		'{32'h27024848, 4, 8'h6B, 3},
		'{32'hA9000000, 2, 8'h68, 2},
		'{32'h24024848, 4, 8'h68, 3},
		'{32'hA7FF0000, 2, 8'h68, 2},
		'{32'hAF010000, 2, 8'h68, 2},
		'{32'hBB800000, 2, 8'h68, 3},
		'{32'hCB018000, 3, 8'h68, 4},
		'{32'hDB000000, 3, 8'h68, 4},
		'{32'hEB000000, 2, 8'h68, 3},
		'{32'hFB000000, 1, 8'h68, 2},
		'{32'h9EEB0100, 3, 8'h68, 4},
		'{32'h9EDB0001, 4, 8'h68, 5},
		'{32'h13900000, 2, 8'h68, 4},
		'{32'h38910000, 2, 8'hEC, 4}
	};

	hbd_core #(.STAB_CYCLES(STAB)) uut (.i_clk(i_clk), .i_srst(i_srst), .i_rdata(i_rdata), .i_irq(i_irq),
		.i_brk(i_brk), .i_monitor(i_monitor), .o_addr(o_addr), .o_rd(o_rd), .o_we(o_we), .o_wdata(o_wdata),
		.o_core_clk_en(o_core_clk_en), .o_break_active(o_break_active), .o_halted(o_halted),
		.o_flags(o_flags), .o_boundary(o_boundary));
	hbd_mem_model u_mem (.i_clk(i_clk), .i_addr(o_addr), .i_rd(o_rd), .i_we(o_we), .i_wdata(o_wdata),
		.o_rdata(i_rdata));

	initial begin
		i_clk = 1'b0;
		forever #4 i_clk = ~i_clk;
	end

	// request held high through the early rows while the mask is set
	always @(posedge i_clk) if (row_i == 6) i_irq <= 1'b0;

	task automatic summarize();
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic cmp_val(input logic [15:0] got, input logic [15:0] exp, input string what);
		comparisons++;
		if (got !== exp) begin
			fails++;
			$display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	task automatic cmp_cnt(input int got, input int lo, input int hi, input string what);
		comparisons++;
		if (got < lo || got > hi) begin
			fails++;
			$display("BAD t=%0t %s count %0d", $time, what, got);
		end
	endtask

	task automatic guard(input int cnt, input int lim);
		if (cnt >= lim) begin
			fails++;
			$display("BAD t=%0t wait ran out", $time);
			summarize();
		end
	endtask

	task automatic push_vec(input logic [15:0] vec);
		w = 0;
		n = 0;
		while (!(w > 0 && o_rd === 1'b1 && o_we !== 1'b1) && n < 40) begin
			if (o_we === 1'b1)
				w++;
			@(negedge i_clk);
			n++;
		end
		guard(n, 40);
		cmp_cnt(w, 5, 5, "stacked bytes");
		cmp_val(o_addr, vec, "vector address");
	endtask

	initial begin
		i_srst = 1'b1;
		i_irq = 1'b1;
		i_brk = 1'b0;
		i_monitor = 1'b0;
		fails = 0;
		comparisons = 0;
		row_i = 0;
		for (int a = 0; a < 65536; a++) u_mem.ram[a] = 8'h00;
		u_mem.ram[16'hFFFE] = 8'h01;
		u_mem.ram[16'hFFFA] = 8'h02;
		u_mem.ram[16'hFFFC] = 8'h03;
		u_mem.ram[16'hFEFC] = 8'h03;
		u_mem.ram[16'h0200] = 8'h80;
		u_mem.ram[16'h0300] = 8'h80;
		u_mem.ram[16'h0090] = 8'hFF;
		u_mem.ram[16'h0091] = 8'h40;
		pc = 16'h0100;
		foreach (rows[i])
			for (int b = 0; b < rows[i].len; b++) begin
				u_mem.ram[pc] = rows[i].code[31 - 8 * b -: 8];
				pc++;
			end
		u_mem.ram[pc] = 8'h8E;
		repeat (6) @(posedge i_clk);
		i_srst <= 1'b0;
		@(negedge i_clk);
		cmp_val(16'(o_flags), 16'h0068, "reset flags");
		n = 0;
		while (!(o_rd === 1'b1 && o_addr === 16'h0100) && n < 20) begin
			@(negedge i_clk);
			n++;
		end
		guard(n, 20);
		$display("test reset done");
		foreach (rows[i]) begin
			row_i = i;
			n = 1;
			while (o_boundary !== 1'b1 && n < 20) begin
				@(negedge i_clk);
				n++;
			end
			guard(n, 20);
			cmp_cnt(n, rows[i].cyc, rows[i].cyc, "cycles");
			@(negedge i_clk);
			cmp_val(16'(o_flags), 16'(rows[i].flg), "flags");
		end
		cmp_val(16'(u_mem.ram[16'h0090]), 16'h00FD, "bit cleared");
		cmp_val(16'(u_mem.ram[16'h0091]), 16'h0080, "shifted byte");
		$display("test opcode rows done");
		n = 0;
		while (o_halted !== 1'b1 && n < 20) begin
			@(negedge i_clk);
			n++;
		end
		guard(n, 20);
		cmp_val(16'(o_flags[3]), 16'h0000, "mask in halt");
		cmp_val(16'(o_core_clk_en), 16'h0000, "clock gated");
		@(posedge i_clk);
		i_irq <= 1'b1;
		@(negedge i_clk);
		n = 0;
		while (o_core_clk_en !== 1'b1 && n < 100) begin
			@(negedge i_clk);
			n++;
		end
		guard(n, 100);
		cmp_cnt(n, STAB + 1, STAB + 3, "wake delay");
		cmp_val(16'(o_flags[3]), 16'h0000, "mask on wake");
		push_vec(16'hFFFA);
		@(posedge i_clk);
		i_irq <= 1'b0;
		@(negedge i_clk);
		n = 0;
		while (o_boundary !== 1'b1 && n < 20) begin
			@(negedge i_clk);
			n++;
		end
		guard(n, 20);
		@(negedge i_clk);
		cmp_val(16'(o_flags[3]), 16'h0000, "mask after return");
		$display("test halt done");
		for (int m = 0; m < 2; m++) begin
			@(posedge i_clk);
			i_monitor <= m[0];
			i_brk <= 1'b1;
			@(negedge i_clk);
			push_vec(m[0] ? 16'hFEFC : 16'hFFFC);
			cmp_val(16'(o_break_active), 16'h0001, "break flag");
			@(posedge i_clk);
			i_brk <= 1'b0;
			n = 0;
			while (o_break_active !== 1'b0 && n < 30) begin
				@(negedge i_clk);
				n++;
			end
			guard(n, 30);
			cmp_cnt(n, 2, 29, "break exit");
			$display("test break %0d done", m);
		end
		summarize();
	end
endmodule // hbd_core_tb_top
